// ==== hdl/upm_pin_mux.sv ====
// Pin mux, USB suspend entry and remote wakeup for the UART bridge.
`timescale 1ns/1ps
`include "upm_cfg.svh"
// Contract
// - Pins reset to GPIO input with pull-up.
// - Pin eight toggles about 10 Hz during transmit.
// - Pin seven drives half-duplex driver enable.
// - Pin six drives programmable clock output.
// - Pin four is clear-to-send, low asserted.
// - Pin five is request-to-send or direction.
// - Pin two is data-set-ready, low asserted.
// - Pin three drives terminal-ready, low asserted.
// - Expose four endpoints, one config, one interface.
// - Report programmable vendor and product identifiers.
// - Begin suspend after 3 ms bus idle.
// - Reach low power within 7 ms.
// - Ring falling edge while suspended requests resume.
// - Attributes advertise remote wakeup by default.
// - Ring wakes only while still an input.
// - Receive activity wakes only if memory enables.
// - Bus state output high while suspended.
module upm_pin_mux
    import upm_pkg::*;
#(
    parameter int unsigned IDLE_CYC   = `UPM_IDLE_CYC,
    parameter int unsigned LOWPWR_CYC = `UPM_LOWPWR_CYC,
    parameter int unsigned ACT_CYC    = `UPM_ACT_HALF_CYC,
    parameter int unsigned WAKE_CYC   = `UPM_WAKE_CYC
)
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    // Pin function selects and GPIO settings, pins two to eight.
    input  wire logic [13:0] i_func_sel,
    input  wire logic [6:0]  i_gpio_dir_out,
    input  wire logic [6:0]  i_gpio_val,
    // Core-side special function sources.
    input  wire logic        i_tx_busy,
    input  wire logic        i_half_duplex_tx,
    input  wire logic        i_clk_wave,
    input  wire logic        i_rts_assert,
    input  wire logic        i_dtr_assert,
    // Pads of pins two to eight.
    input  wire logic [6:0]  i_pad,
    output logic      [6:0]  o_pad_out,
    output logic      [6:0]  o_pad_oe,
    output logic      [6:0]  o_pull_up,
    // Decoded handshake inputs and GPIO readback.
    output logic             o_clear_to_send,
    output logic             o_data_set_ready,
    output logic      [6:0]  o_gpio_in,
    // USB side.
    input  wire logic        i_bus_activity,
    input  wire logic        i_remote_wake_enabled,
    input  wire logic        i_rx_pin,
    input  wire logic        i_ring_wake_in,
    input  wire logic        i_ring_is_input,
    input  wire logic        i_otp_rx_wake_en,
    input  wire logic [15:0] i_otp_vid,
    input  wire logic [15:0] i_otp_pid,
    input  wire logic        i_otp_id_valid,
    output logic      [15:0] o_vendor_id,
    output logic      [15:0] o_product_id,
    output logic      [7:0]  o_config_attr,
    output logic      [2:0]  o_ep_count,
    output logic             o_config_count,
    output logic             o_iface_count,
    output logic             o_suspending,
    output logic             o_low_power,
    output logic             o_resume_req,
    output logic             bus_state_out_a
);
    // Index of each pin in the packed vectors (pin two is bit 0).
    localparam int P_DSR = 0;
    localparam int P_DTR = 1;
    localparam int P_CTS = 2;
    localparam int P_RTS = 3;
    localparam int P_CLK = 4;
    localparam int P_HDX = 5;
    localparam int P_ACT = 6;

    // ==================================================================
    // Helpers
    // ==================================================================
    function automatic upm_func_type sel_of(input logic [13:0] s, input int p);
        sel_of = s[p*2 +: 2];
    endfunction

    typedef struct packed {
        upm_pwr_type  pwr;
        logic [31:0]  idle_cnt;
        logic [31:0]  lp_cnt;
        logic [31:0]  act_cnt;
        logic [31:0]  wake_cnt;
        logic         act_lvl;
        logic         low_power;
        logic         wake_armed;
        logic         ring_s1;
        logic         ring_s2;
        logic         ring_d;
        logic         rx_s1;
        logic         rx_s2;
        logic         rx_d;
        logic         act_s1;
        logic         act_s2;
        logic [15:0]  vid;
        logic [15:0]  pid;
        logic [6:0]   special_val;
    } upm_state_type;

    upm_state_type st_r;
    upm_state_type st_nxt;
    logic [6:0]    special_out;
    logic [6:0]    pad_sync;

    // ==================================================================
    // Special output selection
    // ==================================================================
    always_comb begin
        special_out        = '0;
        special_out[P_ACT] = (sel_of(i_func_sel, P_ACT) == `UPM_FUNC_ALT1);
        special_out[P_HDX] = (sel_of(i_func_sel, P_HDX) == `UPM_FUNC_ALT1);
        special_out[P_CLK] = (sel_of(i_func_sel, P_CLK) == `UPM_FUNC_ALT1);
        special_out[P_RTS] = (sel_of(i_func_sel, P_RTS) != `UPM_FUNC_GPIO);
        special_out[P_DTR] = (sel_of(i_func_sel, P_DTR) == `UPM_FUNC_ALT1);
    end

    genvar g;
    generate
        for (g = 0; g < `UPM_NUM_PINS; g++) begin : gen_pin
            upm_pin_cell u_cell (
                .i_core_clk     (i_core_clk),
                .i_reset        (i_reset),
                .i_special_out  (special_out[g]),
                .i_special_val  (st_r.special_val[g]),
                .i_gpio_dir_out (i_gpio_dir_out[g]),
                .i_gpio_val     (i_gpio_val[g]),
                .i_pad          (i_pad[g]),
                .o_pad_out      (o_pad_out[g]),
                .o_pad_oe       (o_pad_oe[g]),
                .o_pull_up      (o_pull_up[g]),
                .o_pad_sync     (pad_sync[g])
            );
        end
    endgenerate

    // ==================================================================
    // Next state
    // ==================================================================
    always_comb begin
        st_nxt         = st_r;
        st_nxt.ring_s1 = i_ring_wake_in;
        st_nxt.ring_s2 = st_r.ring_s1;
        st_nxt.ring_d  = st_r.ring_s2;
        st_nxt.rx_s1   = i_rx_pin;
        st_nxt.rx_s2   = st_r.rx_s1;
        st_nxt.rx_d    = st_r.rx_s2;
        st_nxt.act_s1  = i_bus_activity;
        st_nxt.act_s2  = st_r.act_s1;

        // Activity indicator: free-running half period while sending, idle high.
        if (i_tx_busy) begin
            if (st_r.act_cnt >= ACT_CYC - 1) begin
                st_nxt.act_cnt = '0;
                st_nxt.act_lvl = ~st_r.act_lvl;
            end else begin
                st_nxt.act_cnt = st_r.act_cnt + 32'h1;
            end
        end else begin
            st_nxt.act_cnt = '0;
            st_nxt.act_lvl = 1'b1;
        end

        st_nxt.special_val[P_ACT] = st_r.act_lvl;
        st_nxt.special_val[P_HDX] = i_half_duplex_tx;
        st_nxt.special_val[P_CLK] = i_clk_wave;
        // Alt2 on pin five is the automatic direction control, active high.
        if (sel_of(i_func_sel, P_RTS) == `UPM_FUNC_ALT2) begin
            st_nxt.special_val[P_RTS] = i_half_duplex_tx;
        end else begin
            st_nxt.special_val[P_RTS] = ~i_rts_assert;
        end
        st_nxt.special_val[P_DTR] = ~i_dtr_assert;
        st_nxt.special_val[P_DSR] = 1'b1;
        st_nxt.special_val[P_CTS] = 1'b1;

        // Identity fields replace the defaults once programmed.
        if (i_otp_id_valid) begin
            st_nxt.vid = i_otp_vid;
            st_nxt.pid = i_otp_pid;
        end

        // The host arms wakeup before suspending; latch it while active.
        if (st_r.pwr == UPM_ST_ACTIVE) begin
            st_nxt.wake_armed = i_remote_wake_enabled;
        end

        case (st_r.pwr)
            UPM_ST_ACTIVE: begin
                st_nxt.low_power = 1'b0;
                st_nxt.lp_cnt    = '0;
                if (st_r.act_s2) begin
                    st_nxt.idle_cnt = '0;
                end else if (st_r.idle_cnt >= IDLE_CYC - 1) begin
                    st_nxt.idle_cnt = '0;
                    st_nxt.pwr      = UPM_ST_ENTER;
                end else begin
                    st_nxt.idle_cnt = st_r.idle_cnt + 32'h1;
                end
            end
            UPM_ST_ENTER: begin
                // Power down at the end of the allowed window.
                if (st_r.act_s2) begin
                    st_nxt.pwr = UPM_ST_ACTIVE;
                end else if (st_r.lp_cnt >= LOWPWR_CYC - 1) begin
                    st_nxt.low_power = 1'b1;
                    st_nxt.pwr       = UPM_ST_SUSPEND;
                end else begin
                    st_nxt.lp_cnt = st_r.lp_cnt + 32'h1;
                end
            end
            UPM_ST_SUSPEND: begin
                st_nxt.wake_cnt = '0;
                if (st_r.act_s2) begin
                    st_nxt.pwr = UPM_ST_ACTIVE;
                end else if (st_r.wake_armed &&
                             ((st_r.ring_d & ~st_r.ring_s2 & i_ring_is_input) ||
                              (st_r.rx_d & ~st_r.rx_s2 & i_otp_rx_wake_en))) begin
                    st_nxt.pwr = UPM_ST_RESUME;
                end
            end
            UPM_ST_RESUME: begin
                if (st_r.wake_cnt >= WAKE_CYC - 1) begin
                    st_nxt.pwr = UPM_ST_ACTIVE;
                end else begin
                    st_nxt.wake_cnt = st_r.wake_cnt + 32'h1;
                end
            end
            default: begin
                st_nxt.pwr = UPM_ST_ACTIVE;
            end
        endcase

        if (i_reset) begin
            st_nxt             = '0;
            st_nxt.pwr         = UPM_ST_ACTIVE;
            st_nxt.act_lvl     = 1'b1;
            st_nxt.ring_s1     = 1'b1;
            st_nxt.ring_s2     = 1'b1;
            st_nxt.ring_d      = 1'b1;
            st_nxt.rx_s1       = 1'b1;
            st_nxt.rx_s2       = 1'b1;
            st_nxt.rx_d        = 1'b1;
            st_nxt.vid         = `UPM_VID_DEFAULT;
            st_nxt.pid         = `UPM_PID_DEFAULT;
            st_nxt.special_val = '1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        st_r <= st_nxt;
    end

    // ==================================================================
    // Outputs
    // ==================================================================
    // Handshake inputs are active low; a GPIO selection reads deasserted.
    assign o_clear_to_send  = (sel_of(i_func_sel, P_CTS) == `UPM_FUNC_ALT1)
                              & ~pad_sync[P_CTS];
    assign o_data_set_ready = (sel_of(i_func_sel, P_DSR) == `UPM_FUNC_ALT1)
                              & ~pad_sync[P_DSR];
    assign o_gpio_in        = pad_sync;
    assign o_vendor_id      = st_r.vid;
    assign o_product_id     = st_r.pid;
    assign o_config_attr    = `UPM_ATTR_REMOTE_WAKE;
    assign o_ep_count       = 3'(`UPM_EP_COUNT);
    assign o_config_count   = 1'(`UPM_CONFIG_COUNT);
    assign o_iface_count    = 1'(`UPM_IFACE_COUNT);
    assign o_suspending     = (st_r.pwr == UPM_ST_ENTER);
    assign o_low_power      = st_r.low_power;
    assign o_resume_req     = (st_r.pwr == UPM_ST_RESUME);
    assign bus_state_out_a  = (st_r.pwr == UPM_ST_SUSPEND);
endmodule

// ==== hdl/upm_cfg.svh ====
// Timing counts, reset values and identity defaults for the UART pin mux block.
`ifndef UPM_CFG_SVH
`define UPM_CFG_SVH
`define UPM_CLK_MHZ           100
`define UPM_IDLE_US           3000
`define UPM_IDLE_CYC          (`UPM_IDLE_US * `UPM_CLK_MHZ)
`define UPM_LOWPWR_US         7000
`define UPM_LOWPWR_CYC        (`UPM_LOWPWR_US * `UPM_CLK_MHZ)
`define UPM_ACT_HALF_MS       50
`define UPM_ACT_HALF_CYC      (`UPM_ACT_HALF_MS * 1000 * `UPM_CLK_MHZ)
`define UPM_WAKE_US           5000
`define UPM_WAKE_CYC          (`UPM_WAKE_US * `UPM_CLK_MHZ)
`define UPM_VID_DEFAULT       16'h1234
`define UPM_PID_DEFAULT       16'h5678
`define UPM_FUNC_GPIO         2'h0
`define UPM_FUNC_ALT1         2'h1
`define UPM_FUNC_ALT2         2'h2
`define UPM_NUM_PINS          7
`define UPM_EP_COUNT          4
`define UPM_CONFIG_COUNT      1
`define UPM_IFACE_COUNT       1
`define UPM_ATTR_REMOTE_WAKE  8'hA0
`endif

// ==== hdl/upm_pkg.sv ====
// Types for the UART pin mux and suspend/wake block.
package upm_pkg;
    typedef enum logic [3:0] {
        UPM_ST_ACTIVE  = 4'h1,
        UPM_ST_ENTER   = 4'h2,
        UPM_ST_SUSPEND = 4'h4,
        UPM_ST_RESUME  = 4'h8
    } upm_pwr_type;
    typedef logic [1:0] upm_func_type;
endpackage

// ==== hdl/upm_pin_cell.sv ====
// One multiplexed UART-side pin: GPIO or special output function.
`timescale 1ns/1ps
`include "upm_cfg.svh"
module upm_pin_cell
    import upm_pkg::*;
(
    // Clock and reset.
    input  wire logic i_core_clk,
    input  wire logic i_reset,
    // Configuration.
    input  wire logic i_special_out,
    input  wire logic i_special_val,
    input  wire logic i_gpio_dir_out,
    input  wire logic i_gpio_val,
    // Pad.
    input  wire logic i_pad,
    output logic      o_pad_out,
    output logic      o_pad_oe,
    output logic      o_pull_up,
    output logic      o_pad_sync
);
    typedef struct packed {
        logic out;
        logic oe;
        logic s1;
        logic s2;
    } upm_cell_type;
    upm_cell_type st_r;
    upm_cell_type st_nxt;
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = i_pad;
        st_nxt.s2 = st_r.s1;
        // A chosen special output overrides GPIO direction.
        if (i_special_out) begin
            st_nxt.oe  = 1'b1;
            st_nxt.out = i_special_val;
        end else begin
            st_nxt.oe  = i_gpio_dir_out;
            st_nxt.out = i_gpio_val;
        end
        if (i_reset) begin
            st_nxt = '0;
        end
    end
    always_ff @(posedge i_core_clk) begin
        st_r <= st_nxt;
    end
    assign o_pad_out  = st_r.out;
    assign o_pad_oe   = st_r.oe;
    assign o_pull_up  = ~st_r.oe;
    assign o_pad_sync = st_r.s2;
endmodule

// ==== sim/upm_pin_mux_monitor.sv ====
// Assertion checker bound to the UART pin mux top.
`timescale 1ns/1ps
module upm_pin_mux_monitor
    import upm_pkg::*;
#(
    parameter int unsigned IDLE_CYC = 20
)
(
    // Clock, reset and sources.
    input wire logic        i_core_clk,
    input wire logic        i_reset,
    input wire logic [13:0] i_func_sel,
    input wire logic        i_half_duplex_tx,
    input wire logic        i_clk_wave,
    input wire logic        i_rts_assert,
    input wire logic        i_dtr_assert,
    input wire logic        i_bus_activity,
    // Watched outputs.
    input wire logic [6:0]  o_pad_out,
    input wire logic [6:0]  o_pad_oe,
    input wire logic [6:0]  o_pull_up,
    input wire logic [6:0]  o_gpio_in,
    input wire logic        o_clear_to_send,
    input wire logic        o_data_set_ready,
    input wire logic        o_suspending,
    input wire logic        o_low_power,
    input wire logic        o_resume_req,
    input wire logic        bus_state_out_a
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // The design syncs activity first, so its idle count can only lag this one.
    logic [31:0] idle_r;
    always_ff @(posedge i_core_clk) begin
        if (i_reset || i_bus_activity) idle_r <= 32'h0;
        else if (idle_r != 32'hFFFFFFFF) idle_r <= idle_r + 32'h1;
    end
    // ====================================================================
    // Pin assertions.
    a_reset_pins_idle: assert property (disable iff (1'b0)
        i_reset |=> (o_pad_oe == 7'h00 && o_pull_up == 7'h7F)) else $error("pads busy in reset");
    a_pullup_when_in: assert property (o_pull_up == ~o_pad_oe)
        else $error("pull-up wrong");
    a_half_duplex_en: assert property ((i_func_sel[11:10] == 2'h1)[*3] |->
        o_pad_oe[5] && o_pad_out[5] == $past(i_half_duplex_tx, 2)) else $error("pin seven");
    a_clock_out_pin: assert property ((i_func_sel[9:8] == 2'h1)[*3] |->
        o_pad_oe[4] && o_pad_out[4] == $past(i_clk_wave, 2)) else $error("pin six");
    a_request_low: assert property ((i_func_sel[7:6] == 2'h1)[*3] |->
        o_pad_oe[3] && o_pad_out[3] == !$past(i_rts_assert, 2)) else $error("pin five");
    a_terminal_low: assert property ((i_func_sel[3:2] == 2'h1)[*3] |->
        o_pad_oe[1] && o_pad_out[1] == !$past(i_dtr_assert, 2)) else $error("pin three");
    a_clear_decode: assert property ((i_func_sel[5:4] == 2'h1) |->
        o_clear_to_send == !o_gpio_in[2]) else $error("clear-to-send");
    a_ready_decode: assert property ((i_func_sel[1:0] == 2'h1) |->
        o_data_set_ready == !o_gpio_in[0]) else $error("data-set-ready");
    // ====================================================================
    // Suspend assertions.
    a_idle_before_sus: assert property (o_suspending |-> idle_r >= IDLE_CYC)
        else $error("early suspend");
    a_state_pin_high: assert property ($rose(bus_state_out_a) |-> o_low_power)
        else $error("state pin early");
    a_wake_from_sus: assert property ($rose(o_resume_req) |-> $past(bus_state_out_a))
        else $error("wake outside suspend");
endmodule
bind upm_pin_mux upm_pin_mux_monitor #(.IDLE_CYC(IDLE_CYC)) u_mon (
    .i_core_clk, .i_reset, .i_func_sel, .i_half_duplex_tx, .i_clk_wave, .i_rts_assert,
    .i_dtr_assert, .i_bus_activity, .o_pad_out, .o_pad_oe, .o_pull_up, .o_gpio_in,
    .o_clear_to_send, .o_data_set_ready, .o_suspending, .o_low_power, .o_resume_req,
    .bus_state_out_a);

// ==== sim/upm_far_model.sv ====
// Far-side model: transceiver pads, ring and receive lines.
`timescale 1ns/1ps
module upm_far_model (
    // Design pad outputs.
    input  wire logic [6:0] i_pad_out,
    input  wire logic [6:0] i_pad_oe,
    input  wire logic [6:0] i_pull_up,
    // Remote party commands.
    input  wire logic [6:0] i_far_en,
    input  wire logic [6:0] i_far_val,
    input  wire logic       i_ring_low,
    input  wire logic       i_rx_low,
    // Resolved lines.
    output logic      [6:0] o_pad,
    output logic            o_ring,
    output logic            o_rx
);
    always_comb begin
        for (int b = 0; b < 7; b++) begin
            if (i_pad_oe[b]) o_pad[b] = i_pad_out[b];
            else if (i_far_en[b]) o_pad[b] = i_far_val[b];
            else o_pad[b] = i_pull_up[b];
        end
    end
    assign o_ring = !i_ring_low;
    assign o_rx   = !i_rx_low;
endmodule

// ==== sim/upm_pin_mux_test.sv ====
// Self-checking bench for the UART pin mux, suspend and wake block.
`timescale 1ns/1ps
`include "upm_cfg.svh"
`define CHECK(a, e) begin \
    tests_run++; \
    if ((a) !== (e)) begin \
        miscompares++; \
        $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
    end \
end
module upm_pin_mux_test;
    import upm_pkg::*;
    localparam int unsigned IDLE = 20;
    localparam int unsigned LOWP = 20;
    localparam int unsigned ACT  = 4;
    localparam int unsigned WAKE = 8;
    // Wake cases: enable, ring is input, memory enable, use receive, expect.
    localparam logic [4:0]  WT [5] = '{5'h19, 5'h0C, 5'h10, 5'h1A, 5'h1F};
    logic        i_core_clk, i_reset, i_tx_busy, i_half_duplex_tx, i_clk_wave;
    logic        i_rts_assert, i_dtr_assert, i_bus_activity, i_remote_wake_enabled;
    logic        i_rx_pin, i_ring_wake_in, i_ring_is_input, i_otp_rx_wake_en, i_otp_id_valid;
    logic        o_clear_to_send, o_data_set_ready, o_config_count, o_iface_count;
    logic        o_suspending, o_low_power, o_resume_req, bus_state_out_a, ring_low, rx_low;
    logic [13:0] i_func_sel;
    logic [6:0]  i_gpio_dir_out, i_gpio_val, i_pad, o_pad_out, o_pad_oe, o_pull_up, o_gpio_in;
    logic [6:0]  far_en, far_val;
    logic [15:0] i_otp_vid, i_otp_pid, o_vendor_id, o_product_id;
    logic [7:0]  o_config_attr;
    logic [2:0]  o_ep_count;
    logic [15:0] exp_q[$];
    int          kind_q[$];
    int          tests_run, miscompares, cycles, tog;
    upm_pin_mux #(.IDLE_CYC(IDLE), .LOWPWR_CYC(LOWP), .ACT_CYC(ACT), .WAKE_CYC(WAKE)) dut (
        .i_core_clk, .i_reset, .i_func_sel, .i_gpio_dir_out, .i_gpio_val, .i_tx_busy,
        .i_half_duplex_tx, .i_clk_wave, .i_rts_assert, .i_dtr_assert, .i_pad, .o_pad_out,
        .o_pad_oe, .o_pull_up, .o_clear_to_send, .o_data_set_ready, .o_gpio_in,
        .i_bus_activity, .i_remote_wake_enabled, .i_rx_pin, .i_ring_wake_in, .i_ring_is_input,
        .i_otp_rx_wake_en, .i_otp_vid, .i_otp_pid, .i_otp_id_valid, .o_vendor_id,
        .o_product_id, .o_config_attr, .o_ep_count, .o_config_count, .o_iface_count,
        .o_suspending, .o_low_power, .o_resume_req, .bus_state_out_a);
    upm_far_model far (.i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe), .i_pull_up(o_pull_up),
        .i_far_en(far_en), .i_far_val(far_val), .i_ring_low(ring_low), .i_rx_low(rx_low),
        .o_pad(i_pad), .o_ring(i_ring_wake_in), .o_rx(i_rx_pin));
    // ====================================================================
    // Helpers.
    function automatic logic [15:0] act(input int k);
        case (k)
            0: return 16'(o_pad_out & 7'h3A);
            1: return 16'(o_pad_oe);
            2: return 16'(o_pull_up);
            3: return {14'h0, o_clear_to_send, o_data_set_ready};
            4: return o_vendor_id;
            5: return o_product_id;
            6: return {13'h0, o_suspending, o_low_power, bus_state_out_a};
            7: return {15'h0, o_resume_req};
            8: return {o_config_attr, 3'h0, o_ep_count, o_config_count, o_iface_count};
            9: return 16'(o_pad_out & o_pad_oe);
            10: return {14'h0, o_pad_oe[6], o_pad_out[6]};
            11: return {14'h0, o_low_power, bus_state_out_a};
            default: return 16'(tog);
        endcase
    endfunction
    task automatic note(input int k, input logic [15:0] e);
        kind_q.push_back(k);
        exp_q.push_back(e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic look();
        @(negedge i_core_clk);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Notes are made at a falling edge; compare just after it, while outputs are settled.
    initial begin
        forever begin
            @(negedge i_core_clk);
            #1;
            while (kind_q.size() > 0) begin
                `CHECK(act(kind_q[0]), exp_q[0])
                void'(kind_q.pop_front());
                void'(exp_q.pop_front());
            end
        end
    end
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    // ====================================================================
    // Main sequence.
    initial begin
        logic [15:0] v;
        logic [15:0] p;
        logic [3:0]  r;
        logic [6:0]  d;
        logic [4:0]  t;
        void'($urandom(32'h9844));
        {i_reset, i_bus_activity, i_ring_is_input} = 3'h7;
        {i_tx_busy, i_half_duplex_tx, i_clk_wave, i_rts_assert, i_dtr_assert} = '0;
        {i_remote_wake_enabled, i_otp_rx_wake_en, i_otp_id_valid, ring_low, rx_low} = '0;
        {i_func_sel, i_gpio_dir_out, i_gpio_val, far_en, far_val, i_otp_vid, i_otp_pid} = '0;
        tick(12);
        i_reset <= 1'b0;
        tick(1);
        look();
        note(1, 16'h0);
        note(2, 16'h7F);
        note(6, 16'h0);
        note(7, 16'h0);
        note(4, `UPM_VID_DEFAULT);
        note(5, `UPM_PID_DEFAULT);
        note(8, {`UPM_ATTR_REMOTE_WAKE, 3'h0, 3'(`UPM_EP_COUNT), 2'h3});
        v = 16'($urandom);
        p = 16'($urandom);
        tick(1);
        {i_otp_vid, i_otp_pid, i_otp_id_valid} <= {v, p, 1'b1};
        tick(1);
        i_otp_id_valid <= 1'b0;
        tick(2);
        look();
        note(4, v);
        note(5, p);
        repeat (4) begin
            d = 7'($urandom);
            v = 16'($urandom);
            tick(1);
            {i_gpio_dir_out, i_gpio_val} <= {d, v[6:0]};
            tick(2);
            look();
            note(1, 16'(d));
            note(9, 16'(d & v[6:0]));
            note(2, {9'h0, ~d});
        end
        tick(1);
        {i_func_sel, i_gpio_dir_out} <= {14'h0544, 7'h00};
        repeat (6) begin
            r = 4'($urandom);
            tick(1);
            {i_half_duplex_tx, i_clk_wave, i_rts_assert, i_dtr_assert} <= r;
            tick(3);
            look();
            note(1, 16'h3A);
            note(0, {10'h0, r[3], r[2], ~r[1], 1'b0, ~r[0], 1'b0});
        end
        // Request-to-send is set equal to the driver enable, so the two pin-five uses differ.
        tick(1);
        {i_func_sel, i_rts_assert} <= {14'h0584, r[3]};
        tick(2);
        look();
        note(1, 16'h3A);
        note(0, {10'h0, r[3], r[2], r[3], 1'b0, ~r[0], 1'b0});
        tick(1);
        {i_func_sel, far_en} <= {14'h0011, 7'h05};
        repeat (4) begin
            r = 4'($urandom);
            tick(1);
            far_val <= {4'h0, r[1], 1'b0, r[0]};
            tick(4);
            look();
            note(3, {14'h0, ~r[1], ~r[0]});
        end
        tick(1);
        {i_func_sel, far_val} <= '0;
        tick(4);
        look();
        note(3, 16'h0);
        tick(1);
        {i_func_sel, i_tx_busy} <= {14'h1000, 1'b0};
        tick(4);
        look();
        note(10, 16'h3);
        tick(1);
        i_tx_busy <= 1'b1;
        tick(2 * ACT);
        look();
        d[0] = o_pad_out[6];
        repeat (3 * ACT) begin
            look();
            if (o_pad_out[6] !== d[0]) tog++;
            d[0] = o_pad_out[6];
        end
        note(12, 16'h3);
        tick(1);
        {i_func_sel, i_gpio_dir_out, i_reset} <= {14'h0544, 7'h7F, 1'b1};
        tick(1);
        look();
        note(1, 16'h0);
        note(2, 16'h7F);
        note(4, `UPM_VID_DEFAULT);
        tick(1);
        {i_func_sel, i_gpio_dir_out, i_reset, i_tx_busy} <= '0;
        for (int i = 0; i < 5; i++) begin
            t = WT[i];
            tick(1);
            {i_bus_activity, i_remote_wake_enabled, i_ring_is_input, i_otp_rx_wake_en}
                <= {1'b1, t[4:2]};
            tick(6);
            i_bus_activity <= 1'b0;
            tick(IDLE - 1);
            look();
            note(6, 16'h0);
            tick(10);
            look();
            note(6, 16'h4);
            tick(LOWP);
            look();
            note(11, 16'h3);
            tick(1);
            {ring_low, rx_low} <= {~t[1], t[1]};
            tick(6);
            look();
            note(7, 16'(t[0]));
            tick(WAKE + 4);
            look();
            note(7, 16'h0);
            tick(1);
            {ring_low, rx_low} <= 2'h0;
        end
        tick(2);
        summarize();
    end
endmodule
